// >>> design/vcs_pkg.sv
// Purpose: shared constants and types for the vliw core state block
// Assumes: one clock, synchronous active-low reset
// Notes: status word layout and opcode codes are local choices
// Behaviour
// - interruptible jump loads destination pc with target
// - source pc updates only on unexcepted jumps
// - software pc write beats same-cycle jump update
// - 64-bit master counter counts since reset
// - count-stalls one counts all, zero skips stalls
// - snapshot copies master on clean jump only
// - cycle reads give snapshot low, high halves
// - current-cycle read gives live master low half
// - booleans are zero or one
// - only bit zero decides boolean or guard
// - integer ops never trap: wrap, clamp, low product
// - single precision float, denormals flushed to zero
// - float results rounded per status rounding mode
// - float-to-int mode or toward-zero; int-to-float mode
// - companion flags ops; sticky flags request traps
// - fixed infinity codes; nan results quieted
// - never emit signalling nan, accept it
// - loads three address modes, stores displacement only
// - scale equals access size one, two, four
// - signed seven-bit displacement in scaled units
// - register specifiers reach at least 128 registers
// - false guard changes nothing except load-immediate
// - count-stalls resets to one
package vcs_pkg;
    localparam int XLEN = 32;
    localparam int CNT_W = 64;
    localparam int SPEC_W = 7;
    localparam int DISP_W = 7;
    localparam int FLAG_W = 7;

    // status word layout
    localparam int PSW_RM_LSB = 0;
    localparam int PSW_CS_BIT = 2;
    localparam int PSW_FLG_LSB = 3;
    localparam int PSW_TRP_LSB = 10;
    localparam logic [XLEN-1:0] PSW_RESET = 32'h0000_0004;
    localparam logic [XLEN-1:0] PSW_MASK = 32'h0001_ffff;

    // flag bit positions
    localparam int FLG_INV = 0;
    localparam int FLG_INX = 3;
    localparam int FLG_IFZ = 6;

    localparam logic [1:0] RM_NEAREST = 2'h0;
    localparam logic [1:0] RM_ZERO = 2'h1;
    localparam logic [1:0] RM_POS = 2'h2;
    localparam logic [1:0] RM_NEG = 2'h3;

    localparam logic [XLEN-1:0] FP_POS_INF = 32'h7f80_0000;
    localparam logic [XLEN-1:0] FP_NEG_INF = 32'hff80_0000;
    localparam logic [XLEN-1:0] FP_QUIET = 32'h0040_0000;
    localparam logic [7:0] FP_EXP_ONES = 8'hff;
    localparam logic [7:0] FP_EXP_BIAS = 8'h7f;
    localparam logic [7:0] F2I_EXACT_EXP = 8'h96;
    localparam logic [7:0] F2I_OVF_EXP = 8'h9e;
    localparam logic [7:0] F2I_SH_MAX = 8'h28;
    localparam logic [5:0] I2F_MANT_POS = 6'h17;
    localparam logic [XLEN-1:0] INT_MAX = 32'h7fff_ffff;
    localparam logic [XLEN-1:0] INT_MIN = 32'h8000_0000;
    localparam logic [XLEN-1:0] BOOL_TRUE = 32'h0000_0001;
    localparam logic [XLEN-1:0] BOOL_FALSE = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_RESET = 64'h0000_0000_0000_0000;
    localparam logic [CNT_W-1:0] CNT_STEP = 64'h0000_0000_0000_0001;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_IMM = 5'h01, OP_IADD = 5'h02, OP_ISUB = 5'h03,
        OP_DSPIADD = 5'h04, OP_IMUL = 5'h05, OP_ILEQ = 5'h06, OP_IEQL = 5'h07,
        OP_CYCLES = 5'h08, OP_HICYCLES = 5'h09, OP_CURCYCLES = 5'h0a,
        OP_READ_DPC = 5'h0b, OP_READ_SPC = 5'h0c, OP_WRITE_DPC = 5'h0d,
        OP_WRITE_SPC = 5'h0e, OP_READ_PSW = 5'h0f, OP_WRITE_PSW = 5'h10,
        OP_IFIX = 5'h11, OP_IFIXRZ = 5'h12, OP_IFLOAT = 5'h13,
        OP_FABS = 5'h14, OP_FNEG = 5'h15
    } vcs_op_t;

    typedef enum logic [1:0] {
        AM_DISP = 2'h0, AM_INDEX = 2'h1, AM_SCALED = 2'h2
    } vcs_amode_t;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0, SZ_HALF = 2'h1, SZ_WORD = 2'h2
    } vcs_size_t;

    typedef struct packed {
        logic valid;
        vcs_op_t opcode;
        logic flags_only;
        logic [XLEN-1:0] guard;
        logic [XLEN-1:0] a;
        logic [XLEN-1:0] b;
        logic [SPEC_W-1:0] dest_spec;
    } vcs_op_req_t;

    typedef struct packed {
        logic valid;
        logic [XLEN-1:0] guard;
        logic exc_taken;
        logic [XLEN-1:0] target;
        logic [XLEN-1:0] source;
    } vcs_jump_t;

    typedef struct packed {
        logic valid;
        logic [XLEN-1:0] guard;
        logic is_store;
        vcs_amode_t mode;
        vcs_size_t size;
        logic [XLEN-1:0] base;
        logic [XLEN-1:0] index;
        logic [DISP_W-1:0] disp;
    } vcs_agen_req_t;
endpackage

// >>> design/vcs_agen.sv
// Purpose: load/store effective address generation
// Assumes: base and index values already read from the register file
// Notes: purely combinational
module vcs_agen (
    // request
    input wire vcs_pkg::vcs_agen_req_t req,
    // answer
    output logic [vcs_pkg::XLEN-1:0] addr,
    output logic illegal
);
    import vcs_pkg::*;

    logic [XLEN-1:0] disp_ext;
    logic [XLEN-1:0] offset;

    // sign-extend the scaled-unit displacement
    assign disp_ext = {{(XLEN-DISP_W){req.disp[DISP_W-1]}}, req.disp};

    always_comb begin
        case (req.mode)
            AM_DISP: offset = disp_ext << req.size;
            AM_INDEX: offset = req.index;
            AM_SCALED: offset = req.index << req.size;
            default: offset = req.index;
        endcase
    end

    assign addr = req.base + offset;
    assign illegal = req.is_store && (req.mode != AM_DISP);
endmodule

// >>> design/vcs_core_state.sv
// Purpose: architectural state and operand semantics of the vliw core
// Assumes: pipeline presents one op, one jump, one address request per cycle
// Notes: all outputs registered
module vcs_core_state (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // pipeline requests
    input wire vcs_pkg::vcs_op_req_t OP_REQ,
    input wire vcs_pkg::vcs_jump_t JUMP,
    input wire vcs_pkg::vcs_agen_req_t AGEN_REQ,
    input wire logic STALL,
    // operation result
    output logic [vcs_pkg::XLEN-1:0] RESULT,
    output logic [vcs_pkg::SPEC_W-1:0] RESULT_SPEC,
    output logic RESULT_VALID,
    // special registers
    output logic [vcs_pkg::XLEN-1:0] DESTINATION_PC,
    output logic [vcs_pkg::XLEN-1:0] SOURCE_PC,
    output logic [vcs_pkg::XLEN-1:0] PROGRAM_STATUS_WORD,
    output logic TRAP_REQ,
    // address generation
    output logic [vcs_pkg::XLEN-1:0] AGEN_ADDR,
    output logic AGEN_VALID,
    output logic AGEN_ILLEGAL
);
    import vcs_pkg::*;

    logic [XLEN-1:0] destination_pc_reg;
    logic [XLEN-1:0] source_pc_reg;
    logic [CNT_W-1:0] master_count_reg;
    logic [CNT_W-1:0] cycle_counter_reg;
    logic [XLEN-1:0] psw_reg;
    logic [XLEN-1:0] psw_next;
    logic [XLEN-1:0] result_reg;
    logic [XLEN-1:0] result_next;
    logic [SPEC_W-1:0] result_spec_reg;
    logic result_valid_reg;
    logic trap_reg;
    logic [XLEN-1:0] agen_addr_reg;
    logic agen_valid_reg;
    logic agen_illegal_reg;
    logic [XLEN-1:0] agen_addr;
    logic agen_illegal;

    logic exec;
    logic jump_fire;
    logic jump_clean;
    logic sw_wr_dpc;
    logic sw_wr_spc;
    logic sw_wr_psw;
    logic is_fp;
    logic [FLAG_W-1:0] op_flags;
    logic [1:0] rm;

    // guard decision from bit zero; load-immediate ignores it
    assign exec = OP_REQ.valid && (OP_REQ.guard[0] || OP_REQ.opcode == OP_IMM);
    assign jump_fire = JUMP.valid && JUMP.guard[0];
    assign jump_clean = jump_fire && !JUMP.exc_taken;
    assign sw_wr_dpc = exec && OP_REQ.opcode == OP_WRITE_DPC;
    assign sw_wr_spc = exec && OP_REQ.opcode == OP_WRITE_SPC;
    assign sw_wr_psw = exec && OP_REQ.opcode == OP_WRITE_PSW;
    assign rm = psw_reg[PSW_RM_LSB+1:PSW_RM_LSB];

    // destination pc
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            destination_pc_reg <= BOOL_FALSE;
        end else if (sw_wr_dpc) begin
            destination_pc_reg <= OP_REQ.a;
        end else if (jump_fire) begin
            destination_pc_reg <= JUMP.target;
        end
    end

    // source pc
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            source_pc_reg <= BOOL_FALSE;
        end else if (sw_wr_spc) begin
            source_pc_reg <= OP_REQ.a;
        end else if (jump_clean) begin
            source_pc_reg <= JUMP.source;
        end
    end

    // master cycle counter
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            master_count_reg <= CNT_RESET;
        end else if (psw_reg[PSW_CS_BIT] || !STALL) begin
            master_count_reg <= master_count_reg + CNT_STEP;
        end
    end

    // snapshot register
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cycle_counter_reg <= CNT_RESET;
        end else if (jump_clean) begin
            cycle_counter_reg <= master_count_reg;
        end
    end

    // float to integer conversion
    logic [1:0] f2i_rm;
    logic [7:0] f2i_sh;
    logic [55:0] f2i_wide;
    logic [XLEN-1:0] f2i_mag;
    logic [XLEN-1:0] f2i_res;
    logic [FLAG_W-1:0] f2i_flags;
    logic f2i_up;

    always_comb begin
        f2i_rm = (OP_REQ.opcode == OP_IFIXRZ) ? RM_ZERO : rm;
        f2i_sh = F2I_EXACT_EXP - OP_REQ.a[30:23];
        f2i_wide = 56'h00_0000_0000_0000;
        f2i_mag = BOOL_FALSE;
        f2i_flags = '0;
        f2i_up = 1'b0;
        if (OP_REQ.a[30:23] == FP_EXP_ONES) begin
            f2i_flags[FLG_INV] = 1'b1;
            f2i_mag = INT_MAX;
        end else if (OP_REQ.a[30:23] == 8'h00) begin
            f2i_flags[FLG_IFZ] = (OP_REQ.a[22:0] != 23'h00_0000);
        end else if (OP_REQ.a[30:23] >= F2I_OVF_EXP) begin
            f2i_flags[FLG_INV] = 1'b1;
            f2i_mag = INT_MAX;
        end else if (OP_REQ.a[30:23] >= F2I_EXACT_EXP) begin
            f2i_mag = {8'h00, 1'b1, OP_REQ.a[22:0]} << (OP_REQ.a[30:23] - F2I_EXACT_EXP);
        end else begin
            if (f2i_sh > F2I_SH_MAX) begin
                f2i_sh = F2I_SH_MAX;
            end
            f2i_wide = {1'b1, OP_REQ.a[22:0], 32'h0000_0000} >> f2i_sh;
            case (f2i_rm)
                RM_NEAREST: f2i_up = f2i_wide[31] && (|f2i_wide[30:0] || f2i_wide[32]);
                RM_POS: f2i_up = !OP_REQ.a[31] && |f2i_wide[31:0];
                RM_NEG: f2i_up = OP_REQ.a[31] && |f2i_wide[31:0];
                default: f2i_up = 1'b0;
            endcase
            f2i_mag = {8'h00, f2i_wide[55:32]} + {31'h0000_0000, f2i_up};
            f2i_flags[FLG_INX] = |f2i_wide[31:0];
        end
        if (f2i_flags[FLG_INV]) begin
            f2i_res = OP_REQ.a[31] ? INT_MIN : INT_MAX;
        end else begin
            f2i_res = OP_REQ.a[31] ? (~f2i_mag + BOOL_TRUE) : f2i_mag;
        end
    end

    // integer to float conversion
    logic [XLEN-1:0] i2f_mag;
    logic [5:0] i2f_pos;
    logic [5:0] i2f_sh;
    logic [63:0] i2f_wide;
    logic [24:0] i2f_mant;
    logic [7:0] i2f_exp;
    logic [XLEN-1:0] i2f_res;
    logic [FLAG_W-1:0] i2f_flags;
    logic i2f_up;

    always_comb begin
        i2f_mag = OP_REQ.a[31] ? (~OP_REQ.a + BOOL_TRUE) : OP_REQ.a;
        i2f_pos = 6'h00;
        for (int i = 0; i < XLEN; i++) begin
            if (i2f_mag[i]) begin
                i2f_pos = 6'(i);
            end
        end
        i2f_flags = '0;
        i2f_up = 1'b0;
        i2f_sh = 6'h00;
        i2f_wide = 64'h0000_0000_0000_0000;
        if (i2f_pos <= I2F_MANT_POS) begin
            i2f_mant = {1'b0, 24'(i2f_mag << (I2F_MANT_POS - i2f_pos))};
        end else begin
            i2f_sh = i2f_pos - I2F_MANT_POS;
            i2f_wide = {i2f_mag, 32'h0000_0000} >> i2f_sh;
            case (rm)
                RM_NEAREST: i2f_up = i2f_wide[31] && (|i2f_wide[30:0] || i2f_wide[32]);
                RM_POS: i2f_up = !OP_REQ.a[31] && |i2f_wide[31:0];
                RM_NEG: i2f_up = OP_REQ.a[31] && |i2f_wide[31:0];
                default: i2f_up = 1'b0;
            endcase
            i2f_mant = {1'b0, i2f_wide[55:32]} + {24'h00_0000, i2f_up};
            i2f_flags[FLG_INX] = |i2f_wide[31:0];
        end
        i2f_exp = FP_EXP_BIAS + {2'h0, i2f_pos};
        if (i2f_mant[24]) begin
            i2f_exp = i2f_exp + 8'h01;
            i2f_mant = i2f_mant >> 1;
        end
        if (i2f_mag == BOOL_FALSE) begin
            i2f_res = BOOL_FALSE;
        end else begin
            i2f_res = {OP_REQ.a[31], i2f_exp, i2f_mant[22:0]};
        end
    end

    // sign operations with special values
    logic [XLEN-1:0] fs_res;
    logic [FLAG_W-1:0] fs_flags;
    logic fs_sign;

    always_comb begin
        fs_flags = '0;
        fs_sign = (OP_REQ.opcode == OP_FNEG) ? !OP_REQ.a[31] : 1'b0;
        if (OP_REQ.a[30:23] == FP_EXP_ONES && OP_REQ.a[22:0] != 23'h00_0000) begin
            fs_res = OP_REQ.a | FP_QUIET;
            fs_flags[FLG_INV] = !OP_REQ.a[22];
        end else if (OP_REQ.a[30:23] == FP_EXP_ONES) begin
            fs_res = fs_sign ? FP_NEG_INF : FP_POS_INF;
        end else if (OP_REQ.a[30:23] == 8'h00) begin
            fs_res = {fs_sign, 31'h0000_0000};
            fs_flags[FLG_IFZ] = (OP_REQ.a[22:0] != 23'h00_0000);
        end else begin
            fs_res = {fs_sign, OP_REQ.a[30:0]};
        end
    end

    // operation result select
    logic [XLEN:0] dsp_sum;
    logic [63:0] mul_full;

    assign dsp_sum = {OP_REQ.a[31], OP_REQ.a} + {OP_REQ.b[31], OP_REQ.b};
    assign mul_full = $signed(OP_REQ.a) * $signed(OP_REQ.b);

    always_comb begin
        is_fp = 1'b0;
        op_flags = '0;
        case (OP_REQ.opcode)
            OP_IMM: result_next = OP_REQ.a;
            OP_IADD: result_next = OP_REQ.a + OP_REQ.b;
            OP_ISUB: result_next = OP_REQ.a - OP_REQ.b;
            OP_DSPIADD: begin
                if (dsp_sum[XLEN] != dsp_sum[XLEN-1]) begin
                    result_next = dsp_sum[XLEN] ? INT_MIN : INT_MAX;
                end else begin
                    result_next = dsp_sum[XLEN-1:0];
                end
            end
            OP_IMUL: result_next = mul_full[XLEN-1:0];
            OP_ILEQ: result_next = ($signed(OP_REQ.a) <= $signed(OP_REQ.b)) ? BOOL_TRUE : BOOL_FALSE;
            OP_IEQL: result_next = (OP_REQ.a == OP_REQ.b) ? BOOL_TRUE : BOOL_FALSE;
            OP_CYCLES: result_next = cycle_counter_reg[XLEN-1:0];
            OP_HICYCLES: result_next = cycle_counter_reg[CNT_W-1:XLEN];
            OP_CURCYCLES: result_next = master_count_reg[XLEN-1:0];
            OP_READ_DPC: result_next = destination_pc_reg;
            OP_READ_SPC: result_next = source_pc_reg;
            OP_READ_PSW: result_next = psw_reg;
            OP_IFIX, OP_IFIXRZ: begin
                is_fp = 1'b1;
                op_flags = f2i_flags;
                result_next = f2i_res;
            end
            OP_IFLOAT: begin
                is_fp = 1'b1;
                op_flags = i2f_flags;
                result_next = i2f_res;
            end
            OP_FABS, OP_FNEG: begin
                is_fp = 1'b1;
                op_flags = fs_flags;
                result_next = fs_res;
            end
            default: result_next = BOOL_FALSE;
        endcase
        if (is_fp && OP_REQ.flags_only) begin
            result_next = {{(XLEN-FLAG_W){1'b0}}, op_flags};
        end
    end

    // status word: software write, then hardware sticky sets win
    always_comb begin
        psw_next = sw_wr_psw ? (OP_REQ.a & PSW_MASK) : psw_reg;
        if (exec && is_fp && !OP_REQ.flags_only) begin
            psw_next[PSW_FLG_LSB +: FLAG_W] = psw_next[PSW_FLG_LSB +: FLAG_W] | op_flags;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            psw_reg <= PSW_RESET;
        end else begin
            psw_reg <= psw_next;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            trap_reg <= 1'b0;
        end else begin
            trap_reg <= |(psw_next[PSW_FLG_LSB +: FLAG_W] & psw_next[PSW_TRP_LSB +: FLAG_W]);
        end
    end

    // result register
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            result_reg <= BOOL_FALSE;
            result_spec_reg <= '0;
            result_valid_reg <= 1'b0;
        end else begin
            result_valid_reg <= exec && OP_REQ.opcode != OP_NOP;
            if (exec) begin
                result_reg <= result_next;
                result_spec_reg <= OP_REQ.dest_spec;
            end
        end
    end

    // address generation
    vcs_agen u_agen (
        .req(AGEN_REQ),
        .addr(agen_addr),
        .illegal(agen_illegal)
    );

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            agen_addr_reg <= BOOL_FALSE;
            agen_valid_reg <= 1'b0;
            agen_illegal_reg <= 1'b0;
        end else begin
            agen_valid_reg <= AGEN_REQ.valid && AGEN_REQ.guard[0] && !agen_illegal;
            agen_illegal_reg <= AGEN_REQ.valid && AGEN_REQ.guard[0] && agen_illegal;
            if (AGEN_REQ.valid && AGEN_REQ.guard[0]) begin
                agen_addr_reg <= agen_addr;
            end
        end
    end

    assign RESULT = result_reg;
    assign RESULT_SPEC = result_spec_reg;
    assign RESULT_VALID = result_valid_reg;
    assign DESTINATION_PC = destination_pc_reg;
    assign SOURCE_PC = source_pc_reg;
    assign PROGRAM_STATUS_WORD = psw_reg;
    assign TRAP_REQ = trap_reg;
    assign AGEN_ADDR = agen_addr_reg;
    assign AGEN_VALID = agen_valid_reg;
    assign AGEN_ILLEGAL = agen_illegal_reg;
endmodule

// >>> test/vcs_core_state_props.sv
// Purpose: concurrent checks on the vliw core state ports
// Assumes: one clock, synchronous active-low reset
// Notes: bound to vcs_core_state
module vcs_core_state_props (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // requests
    input wire vcs_pkg::vcs_op_req_t OP_REQ,
    input wire vcs_pkg::vcs_jump_t JUMP,
    input wire vcs_pkg::vcs_agen_req_t AGEN_REQ,
    input wire logic STALL,
    // answers
    input wire logic [vcs_pkg::XLEN-1:0] RESULT,
    input wire logic [vcs_pkg::SPEC_W-1:0] RESULT_SPEC,
    input wire logic RESULT_VALID,
    input wire logic [vcs_pkg::XLEN-1:0] DESTINATION_PC,
    input wire logic [vcs_pkg::XLEN-1:0] SOURCE_PC,
    input wire logic [vcs_pkg::XLEN-1:0] PROGRAM_STATUS_WORD,
    input wire logic TRAP_REQ,
    input wire logic [vcs_pkg::XLEN-1:0] AGEN_ADDR,
    input wire logic AGEN_VALID,
    input wire logic AGEN_ILLEGAL
);
    timeunit 1ns;
    timeprecision 100ps;
    import vcs_pkg::*;
    logic op_go, jmp_go, ag_go, wr_dpc, wr_spc;
    logic [XLEN-1:0] sum_w, ea_w;
    assign op_go = OP_REQ.valid && (OP_REQ.guard[0] || OP_REQ.opcode == OP_IMM);
    assign jmp_go = JUMP.valid && JUMP.guard[0];
    assign ag_go = AGEN_REQ.valid && AGEN_REQ.guard[0];
    assign wr_dpc = op_go && OP_REQ.opcode == OP_WRITE_DPC;
    assign wr_spc = op_go && OP_REQ.opcode == OP_WRITE_SPC;
    assign sum_w = OP_REQ.a + OP_REQ.b;
    assign ea_w = AGEN_REQ.base + ({{25{AGEN_REQ.disp[6]}}, AGEN_REQ.disp} << AGEN_REQ.size);

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    dpc_load_a: assert property (jmp_go && !wr_dpc |=> DESTINATION_PC == $past(JUMP.target))
        else $error("destination pc missed jump target");
    spc_hold_a: assert property (jmp_go && JUMP.exc_taken && !wr_spc |=> $stable(SOURCE_PC))
        else $error("source pc moved on excepted jump");
    sw_wins_a: assert property (wr_dpc |=> DESTINATION_PC == $past(OP_REQ.a))
        else $error("software destination pc write lost");
    guard_off_a: assert property (OP_REQ.valid && !op_go |=> !RESULT_VALID)
        else $error("result from guarded-off op");
    spec_pass_a: assert property (op_go && OP_REQ.opcode != OP_NOP |=>
        RESULT_VALID && RESULT_SPEC == $past(OP_REQ.dest_spec))
        else $error("result valid or spec wrong");
    bool_form_a: assert property (op_go && OP_REQ.opcode inside {OP_ILEQ, OP_IEQL} |=>
        RESULT[31:1] == 31'h0)
        else $error("boolean result not zero or one");
    add_wrap_a: assert property (op_go && OP_REQ.opcode == OP_IADD |=> RESULT == $past(sum_w))
        else $error("add did not wrap");
    st_mode_a: assert property (ag_go && AGEN_REQ.is_store && AGEN_REQ.mode != AM_DISP |=>
        AGEN_ILLEGAL && !AGEN_VALID)
        else $error("store with indexed mode accepted");
    disp_scale_a: assert property (ag_go && AGEN_REQ.mode == AM_DISP |=> AGEN_ADDR == $past(ea_w))
        else $error("scaled displacement address wrong");
    trap_level_a: assert property (TRAP_REQ == |(PROGRAM_STATUS_WORD[16:10] & PROGRAM_STATUS_WORD[9:3]))
        else $error("trap request disagrees with status word");

    cover property (jmp_go && !JUMP.exc_taken);
    cover property (AGEN_ILLEGAL);
    cover property (TRAP_REQ);
endmodule

bind vcs_core_state vcs_core_state_props i_vcs_core_state_props (
    .CLK(CLK), .RST_N(RST_N), .OP_REQ(OP_REQ), .JUMP(JUMP), .AGEN_REQ(AGEN_REQ),
    .STALL(STALL), .RESULT(RESULT), .RESULT_SPEC(RESULT_SPEC), .RESULT_VALID(RESULT_VALID),
    .DESTINATION_PC(DESTINATION_PC), .SOURCE_PC(SOURCE_PC),
    .PROGRAM_STATUS_WORD(PROGRAM_STATUS_WORD), .TRAP_REQ(TRAP_REQ), .AGEN_ADDR(AGEN_ADDR),
    .AGEN_VALID(AGEN_VALID), .AGEN_ILLEGAL(AGEN_ILLEGAL));

// >>> test/vcs_core_state_tb.sv
// Purpose: directed bench for the vliw core state block
// Assumes: inputs change at the falling edge
// Notes: expectations worked out here
module vcs_core_state_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import vcs_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic stall = 1'b0;
    vcs_op_req_t op_req = '0;
    vcs_jump_t jump = '0;
    vcs_agen_req_t agen_req = '0;
    logic [XLEN-1:0] result, destination_pc, source_pc, psw, agen_addr, r, c;
    logic [SPEC_W-1:0] result_spec;
    logic result_valid, trap_req, agen_valid, agen_illegal;
    logic [XLEN-1:0] fix_pos [4] = '{32'h1, 32'h1, 32'h2, 32'h1};
    logic [XLEN-1:0] fix_neg [4] = '{32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_fffe};
    logic [XLEN-1:0] flt [4] = '{32'h4b80_0000, 32'h4b80_0000, 32'h4b80_0001, 32'h4b80_0000};
    int n_fail = 0;
    int checks_done = 0;
    always #2 clk = ~clk;

    vcs_core_state i_vcs_core_state (
        .CLK(clk), .RST_N(rst_n), .OP_REQ(op_req), .JUMP(jump), .AGEN_REQ(agen_req),
        .STALL(stall), .RESULT(result), .RESULT_SPEC(result_spec), .RESULT_VALID(result_valid),
        .DESTINATION_PC(destination_pc), .SOURCE_PC(source_pc), .PROGRAM_STATUS_WORD(psw), .TRAP_REQ(trap_req),
        .AGEN_ADDR(agen_addr), .AGEN_VALID(agen_valid), .AGEN_ILLEGAL(agen_illegal));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [XLEN-1:0] seen, input logic [XLEN-1:0] e);
        checks_done++;
        if (seen !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, seen);
        end
    endtask
    task automatic op(input vcs_op_t o, input logic [XLEN-1:0] a, b, g = 1,
                      input logic f = 0, input vcs_jump_t j = '0);
        @(negedge clk);
        op_req = '{1'b1, o, f, g, a, b, 7'h7f};
        jump = j;
        @(negedge clk);
        op_req.valid = 1'b0;
        jump.valid = 1'b0;
        r = result;
        if (o != OP_NOP)
            chk("valid", result_valid, g[0] || o == OP_IMM);
    endtask
    task automatic ex(input string nm, input vcs_op_t o, input logic [XLEN-1:0] a, b, e,
                      input logic [XLEN-1:0] g = 1, input logic f = 0);
        op(o, a, b, g, f);
        chk(nm, r, e);
    endtask
    task automatic ag(input logic st, input vcs_amode_t m, input vcs_size_t s,
                      input logic [XLEN-1:0] base, idx, input logic [6:0] d);
        @(negedge clk);
        agen_req = '{1'b1, 32'h1, st, m, s, base, idx, d};
        @(negedge clk);
        agen_req.valid = 1'b0;
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        chk("psw", psw, 32'h0000_0004);
        ex("cycles", OP_CYCLES, 0, 0, 0);
        ex("hicycles", OP_HICYCLES, 0, 0, 0);
    endtask
    task automatic cur_gap(input logic stl, input logic [XLEN-1:0] e);
        logic [XLEN-1:0] c0;
        stall = stl;
        op(OP_CURCYCLES, 0, 0);
        c0 = r;
        repeat (10) @(negedge clk);
        op(OP_CURCYCLES, 0, 0);
        chk("cur gap", r - c0, e);
        stall = 1'b0;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        wrap_up();
    end
    initial begin
        do_reset();
        ex("iadd", OP_IADD, 32'h7fff_ffff, 32'h1, 32'h8000_0000);
        ex("isub", OP_ISUB, 0, 32'h1, 32'hffff_ffff);
        ex("dsp hi", OP_DSPIADD, 32'h7fff_ffff, 32'h1, INT_MAX);
        ex("dsp lo", OP_DSPIADD, 32'h8000_0000, 32'hffff_ffff, INT_MIN);
        ex("imul", OP_IMUL, 32'h1234_5678, 32'h10, 32'h2345_6780);
        ex("ileq", OP_ILEQ, 32'hffff_ffff, 32'h1, 32'h1);
        ex("ieql", OP_IEQL, 32'h3, 32'h4, 0);
        ex("guard lsb", OP_IEQL, 32'h5, 32'h5, 32'h1, 32'h3);
        chk("spec", result_spec, 32'h7f);
        ex("imm", OP_IMM, 32'h1234_5678, 0, 32'h1234_5678, 0);
        ex("held", OP_IADD, 32'h1, 32'h1, 32'h1234_5678, 32'hffff_fffe);
        op(OP_WRITE_DPC, 32'hdead_0000, 0, 32'h2);
        chk("dpc off", destination_pc, 0);
        $display("integer test done");
        ex("fneg", OP_FNEG, 32'h3f80_0000, 0, 32'hbf80_0000);
        ex("fabs inf", OP_FABS, FP_NEG_INF, 0, FP_POS_INF);
        ex("flags", OP_FABS, 32'h7f80_0001, 0, 32'h1, 32'h1, 1'b1);
        chk("sticky", psw, 32'h0000_0004);
        ex("nan", OP_FNEG, 32'h7f80_0001, 0, 32'h7fc0_0001);
        ex("read psw", OP_READ_PSW, 0, 0, 32'h0000_000c);
        ex("denorm", OP_IFIX, 32'h1, 0, 0);
        for (int m = 0; m < 4; m++) begin
            op(OP_WRITE_PSW, 32'h4 | m, 0);
            ex("ifix pos", OP_IFIX, 32'h3fa0_0000, 0, fix_pos[m]);
            ex("ifix neg", OP_IFIX, 32'hbfa0_0000, 0, fix_neg[m]);
            ex("ifixrz", OP_IFIXRZ, 32'hbfa0_0000, 0, 32'hffff_ffff);
            ex("ifloat", OP_IFLOAT, 32'h0100_0001, 0, flt[m]);
        end
        op(OP_WRITE_PSW, 32'h0000_0404, 0);
        chk("trap off", trap_req, 0);
        op(OP_FABS, 32'h7f80_0001, 0);
        chk("trap on", trap_req, 1);
        chk("psw inv", psw & 32'h8, 32'h8);
        op(OP_WRITE_PSW, 32'h0000_0004, 0);
        chk("trap clr", trap_req, 0);
        $display("float test done");
        cur_gap(1, 12);
        op(OP_WRITE_PSW, 0, 0);
        cur_gap(1, 0);
        cur_gap(0, 12);
        op(OP_WRITE_PSW, 32'h0000_0004, 0);
        op(OP_CURCYCLES, 0, 0, 1, 0, '{1'b1, 32'h1, 1'b0, 32'h0000_1000, 32'h0000_2000});
        c = r;
        chk("dpc", destination_pc, 32'h0000_1000);
        chk("spc", source_pc, 32'h0000_2000);
        ex("snap", OP_CYCLES, 0, 0, c);
        ex("snap hi", OP_HICYCLES, 0, 0, 0);
        op(OP_NOP, 0, 0, 1, 0, '{1'b1, 32'h1, 1'b1, 32'h0000_3000, 32'h0000_4000});
        chk("dpc exc", destination_pc, 32'h0000_3000);
        chk("spc exc", source_pc, 32'h0000_2000);
        ex("snap exc", OP_CYCLES, 0, 0, c);
        op(OP_NOP, 0, 0, 1, 0, '{1'b1, 32'h2, 1'b0, 32'h0000_5000, 32'h0000_6000});
        chk("dpc off", destination_pc, 32'h0000_3000);
        op(OP_WRITE_DPC, 32'h0000_7000, 0, 1, 0, '{1'b1, 32'h1, 1'b0, 32'h0000_8000, 32'h0000_9000});
        chk("dpc sw", destination_pc, 32'h0000_7000);
        chk("spc hw", source_pc, 32'h0000_9000);
        op(OP_WRITE_SPC, 32'h0000_a000, 0, 1, 0, '{1'b1, 32'h1, 1'b0, 32'h0000_8000, 32'h0000_9000});
        chk("spc sw", source_pc, 32'h0000_a000);
        ex("read spc", OP_READ_SPC, 0, 0, 32'h0000_a000);
        ex("read dpc", OP_READ_DPC, 0, 0, 32'h0000_8000);
        $display("counter test done");
        ag(0, AM_DISP, SZ_WORD, 32'h0000_0100, 0, 7'h7e);
        chk("ld32d", agen_addr, 32'h0000_00f8);
        ag(0, AM_DISP, SZ_BYTE, 32'h0000_0100, 0, 7'h3f);
        chk("ld8d", agen_addr, 32'h0000_013f);
        ag(0, AM_INDEX, SZ_HALF, 32'h0000_0010, 32'h3, 0);
        chk("ld16r", agen_addr, 32'h0000_0013);
        ag(0, AM_SCALED, SZ_WORD, 32'h0000_0010, 32'h3, 0);
        chk("ld32x", agen_addr, 32'h0000_001c);
        ag(1, AM_DISP, SZ_HALF, 32'h0000_0100, 0, 7'h40);
        chk("st16d", agen_addr, 32'h0000_0080);
        chk("st valid", agen_valid, 1);
        ag(1, AM_INDEX, SZ_WORD, 32'h0000_0100, 32'h4, 0);
        chk("st bad", agen_illegal, 1);
        chk("st none", agen_valid, 0);
        $display("address test done");
        do_reset();
        $display("reset test done");
        wrap_up();
    end
endmodule
